// ---- rtl/service_serial_port_alarm_out.v ----
/*
 Service serial port: breath pulses, alarm outputs, test modes.
 Holds register port, DTR and alarm pin drive, defaults, interrupt.
 Assumes inputs synchronous to sys_clk and an outside nonvolatile
 store that shows saved values and takes new ones on nvStore.
*/
// Implementation choices: the register offsets and strobed register access.
// Operation
// - with breath pulses on, each detected breath gives one DTR pulse, none when off.
// - the breath-pulse enable also updates its stored power-on default.
// - the bit rate is a stored default kept and reported in hundreds of baud.
// - characters are 8 data bits, no parity, 1 stop bit, 19200 baud unless changed.
// - in loopback mode each received character is sent back unchanged.
// - transmit test mode sends bytes 0 to 255 in order, repeatedly.
// - both test modes can only be entered while running on mains power.
// - the alarm pin floats with no alarm and is pulled low while any alarm sounds and is not silenced.
// - expansion-unit alarms count too, on mains or battery alike.
// - with the alarm function enabled at power-on, DTR goes high while an alarm sounds.
// - DTR returns low when the alarm is silenced or ends.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.vh"

module service_serial_port_alarm_out #(
   parameter [17:0] PULSE_CYC = `BREATH_PULSE_US * `CLK_MHZ
) (
   input  wire              sys_clk,
   input  wire              rst,
   input  wire [4:0]        regAddr,
   input  wire [31:0]       regWrData,
   input  wire              regWr,
   input  wire              regRd,
   output reg  [31:0]       regRdData,
   input  wire              rxd,
   output wire              txd,
   output reg               dtrOut,
   output reg               alarmPinOut,
   output reg               alarmPinOe,
   input  wire              mainsPower,
   input  wire              alarmSounding,
   input  wire              expAlarmSounding,
   input  wire              alarmSilenced,
   input  wire              alarmFnStrap,
   input  wire              breathDetect,
   input  wire              nvBreathIn,
   input  wire [10:0]       nvBaudIn,
   output reg               nvStore,
   output reg               nvBreathOut,
   output reg  [10:0]       nvBaudOut,
   output reg               irq
);

   // ----------------------------------------------------------------
   // divider for a bit rate given in hundreds of baud
   // ----------------------------------------------------------------
   function [`DIV_W-1:0] divFromHundreds;
      input [`BAUD_W-1:0] h;
      reg   [31:0]        q;
      begin
         q = `CYC_PER_HUNDRED / {21'h000000, h};
         divFromHundreds = q[`DIV_W-1:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg              loadPend_q;
   reg              alarmFnEn_q;
   reg              breathEn_q;
   reg [1:0]        mode_q;
   reg [`DIV_W-1:0] bitDiv_q;
   reg              hold_q;
   reg [7:0]        holdData_q;
   reg [7:0]        pattern_q;
   reg              rxFull_q;
   reg [7:0]        rxData_q;
   reg [`IRQ_W-1:0] irqStat_q;
   reg [`IRQ_W-1:0] irqMask_q;
   reg [17:0]       pulseCnt_q;
   reg              breathPrev_q;
   reg              alarmPrev_q;
   reg              txBusyPrev_q;

   wire             txBusy;
   wire             rxValid;
   wire [7:0]       rxByte;
   wire             rxFrameErr;
   reg              txStart;
   reg  [7:0]       txByte;
   reg  [`IRQ_W-1:0] irqEvt;
   reg  [31:0]      rdMux;

   wire alarmActive = (alarmSounding | expAlarmSounding) & ~alarmSilenced;
   wire breathRise  = breathDetect & ~breathPrev_q;
   wire wrCtrl      = regWr && (regAddr == `REG_CTRL);
   wire wrBaud      = regWr && (regAddr == `REG_BAUD);
   wire wrTx        = regWr && (regAddr == `REG_TXDATA);
   wire [1:0] wrMode = regWrData[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire [`BAUD_W-1:0] wrBaudVal = regWrData[`BAUD_W-1:0];

   // ----------------------------------------------------------------
   // serial engines
   // ----------------------------------------------------------------
   uart_tx_engine txEngine (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bitDiv  (bitDiv_q),
      .start   (txStart),
      .data    (txByte),
      .txd     (txd),
      .busy    (txBusy)
   );

   uart_rx_engine rxEngine (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .bitDiv   (bitDiv_q),
      .rxd      (rxd),
      .valid    (rxValid),
      .data     (rxByte),
      .frameErr (rxFrameErr)
   );

   // ----------------------------------------------------------------
   // next character for the transmitter
   // ----------------------------------------------------------------
   always @* begin
      txStart = 1'b0;
      txByte  = holdData_q;
      if (!txBusy) begin
         if (mode_q == `MODE_TXTEST) begin
            txStart = 1'b1;
            txByte  = pattern_q;
         end else begin
            txStart = hold_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt events
   // ----------------------------------------------------------------
   always @* begin
      irqEvt = {`IRQ_W{1'b0}};
      irqEvt[`IRQ_RX]     = rxValid;
      irqEvt[`IRQ_TX]     = txBusyPrev_q & ~txBusy;
      irqEvt[`IRQ_BREATH] = breathRise & breathEn_q;
      irqEvt[`IRQ_ALARM]  = alarmActive & ~alarmPrev_q;
      irqEvt[`IRQ_FRAME]  = rxFrameErr;
   end

   // ----------------------------------------------------------------
   // configuration, modes and stored defaults
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         loadPend_q  <= 1'b1;
         alarmFnEn_q <= 1'b0;
         breathEn_q  <= 1'b0;
         mode_q      <= `MODE_NORMAL;
         bitDiv_q    <= divFromHundreds(`BAUD_DEF_H);
         nvStore     <= 1'b0;
         nvBreathOut <= 1'b0;
         nvBaudOut   <= `BAUD_DEF_H;
      end else begin
         nvStore <= 1'b0;
         if (loadPend_q) begin
            loadPend_q  <= 1'b0;
            alarmFnEn_q <= alarmFnStrap;
            breathEn_q  <= nvBreathIn;
            nvBreathOut <= nvBreathIn;
            if (nvBaudIn != {`BAUD_W{1'b0}}) begin
               nvBaudOut <= nvBaudIn;
               bitDiv_q  <= divFromHundreds(nvBaudIn);
            end
         end else begin
            if (wrCtrl) begin
               breathEn_q  <= regWrData[`CTRL_BREATH];
               nvBreathOut <= regWrData[`CTRL_BREATH];
               nvStore     <= regWrData[`CTRL_BREATH] != breathEn_q;
               if (wrMode == `MODE_NORMAL || mainsPower)
                  mode_q <= (wrMode == `MODE_TXTEST) ? `MODE_TXTEST :
                            (wrMode == `MODE_LOOPBACK) ? `MODE_LOOPBACK : `MODE_NORMAL;
            end
            if (!mainsPower)
               mode_q <= `MODE_NORMAL;
            if (wrBaud && wrBaudVal != {`BAUD_W{1'b0}}) begin
               nvBaudOut <= wrBaudVal;
               bitDiv_q  <= divFromHundreds(wrBaudVal);
               nvStore   <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // hold, pattern and receive registers
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         hold_q     <= 1'b0;
         holdData_q <= 8'h00;
         pattern_q  <= 8'h00;
         rxFull_q   <= 1'b0;
         rxData_q   <= 8'h00;
      end else begin
         if (txStart && mode_q == `MODE_TXTEST)
            pattern_q <= pattern_q + 8'h01;   // wraps 255 to 0
         else if (mode_q != `MODE_TXTEST)
            pattern_q <= 8'h00;
         if (txStart && mode_q != `MODE_TXTEST)
            hold_q <= 1'b0;
         if (mode_q == `MODE_LOOPBACK && rxValid) begin
            hold_q     <= 1'b1;
            holdData_q <= rxByte;
         end else if (mode_q == `MODE_NORMAL && wrTx && !hold_q) begin
            hold_q     <= 1'b1;
            holdData_q <= regWrData[7:0];
         end
         if (regRd && regAddr == `REG_RXDATA)
            rxFull_q <= 1'b0;
         if (rxValid && mode_q == `MODE_NORMAL) begin
            rxFull_q <= 1'b1;                 // set wins over read-clear
            rxData_q <= rxByte;
         end
      end
   end

   // ----------------------------------------------------------------
   // DTR and alarm pin drive
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         pulseCnt_q   <= 18'h00000;
         breathPrev_q <= 1'b0;
         alarmPrev_q  <= 1'b0;
         dtrOut       <= 1'b0;
         alarmPinOut  <= 1'b0;
         alarmPinOe   <= 1'b0;
      end else begin
         breathPrev_q <= breathDetect;
         alarmPrev_q  <= alarmActive;
         if (breathRise && breathEn_q)
            pulseCnt_q <= PULSE_CYC;
         else if (pulseCnt_q != 18'h00000)
            pulseCnt_q <= pulseCnt_q - 18'h00001;
         dtrOut <= (alarmFnEn_q & alarmActive) |
                   (breathEn_q & (pulseCnt_q != 18'h00000));
         alarmPinOut <= 1'b0;                 // only ever pulls low
         alarmPinOe  <= alarmActive;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and output
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         irqStat_q    <= {`IRQ_W{1'b0}};
         irqMask_q    <= {`IRQ_W{1'b0}};
         irq          <= 1'b0;
         txBusyPrev_q <= 1'b0;
      end else begin
         txBusyPrev_q <= txBusy;
         if (regWr && regAddr == `REG_IRQ_MASK)
            irqMask_q <= regWrData[`IRQ_W-1:0];
         if (regWr && regAddr == `REG_IRQ_STAT)
            irqStat_q <= (irqStat_q & ~regWrData[`IRQ_W-1:0]) | irqEvt;
         else
            irqStat_q <= irqStat_q | irqEvt;
         irq <= |(irqStat_q & irqMask_q);
      end
   end

   // ----------------------------------------------------------------
   // read decode, answered one cycle later
   // ----------------------------------------------------------------
   always @* begin
      rdMux = 32'h00000000;
      case (regAddr)
         `REG_CTRL: begin
            rdMux[`CTRL_BREATH] = breathEn_q;
            rdMux[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_q;
         end
         `REG_BAUD:     rdMux[`BAUD_W-1:0] = nvBaudOut;
         `REG_STATUS:   rdMux[6:0] = {alarmFnEn_q, alarmActive, mainsPower,
                                      hold_q, rxFull_q, txBusy, dtrOut};
         `REG_RXDATA:   rdMux[7:0] = rxData_q;
         `REG_IRQ_STAT: rdMux[`IRQ_W-1:0] = irqStat_q;
         `REG_IRQ_MASK: rdMux[`IRQ_W-1:0] = irqMask_q;
         default:       rdMux = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst)
         regRdData <= 32'h00000000;
      else if (regRd)
         regRdData <= rdMux;
      else
         regRdData <= 32'h00000000;
   end

endmodule
`default_nettype wire

// ---- rtl/ssp_consts.vh ----
/*
 Shared constants: clock, bit-rate defaults, offsets, fields, modes.
 Assumes inclusion by bare name from each design file.
*/
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_HZ            25000000
`define CLK_MHZ           25
`define CYC_PER_HUNDRED   (`CLK_HZ / 100)
`define BREATH_PULSE_US   10000
`define BAUD_DEF_H        11'h0c0
`define DIV_W             18
`define BAUD_W            11

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL          5'h00
`define REG_BAUD          5'h04
`define REG_STATUS        5'h08
`define REG_TXDATA        5'h0c
`define REG_RXDATA        5'h10
`define REG_IRQ_STAT      5'h14
`define REG_IRQ_MASK      5'h18

// ----------------------------------------------------------------
// fields and encodings
// ----------------------------------------------------------------
`define CTRL_BREATH       0
`define CTRL_MODE_LO      1
`define CTRL_MODE_HI      2
`define MODE_NORMAL       2'h0
`define MODE_LOOPBACK     2'h1
`define MODE_TXTEST       2'h2
`define IRQ_W             5
`define IRQ_RX            0
`define IRQ_TX            1
`define IRQ_BREATH        2
`define IRQ_ALARM         3
`define IRQ_FRAME         4
`define FRAME_BITS        4'h9

`endif

// ---- rtl/uart_rx_engine.v ----
/*
 Receive engine: 8N1 character, sampled at mid-bit.
 Assumes rxd already synchronous to sys_clk, idle high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.vh"

module uart_rx_engine (
   input  wire              sys_clk,
   input  wire              rst,
   input  wire [`DIV_W-1:0] bitDiv,
   input  wire              rxd,
   output reg               valid,
   output reg  [7:0]        data,
   output reg               frameErr
);

   reg [`DIV_W-1:0] cnt_q;
   reg [3:0]        bitIdx_q;
   reg              active_q;

   // ----------------------------------------------------------------
   // hunt for start, then sample each bit centre
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         valid    <= 1'b0;
         frameErr <= 1'b0;
         data     <= 8'h00;
         cnt_q    <= {`DIV_W{1'b0}};
         bitIdx_q <= 4'h0;
         active_q <= 1'b0;
      end else begin
         valid    <= 1'b0;
         frameErr <= 1'b0;
         if (!active_q) begin
            if (!rxd) begin
               active_q <= 1'b1;
               bitIdx_q <= 4'h0;
               cnt_q    <= {1'b0, bitDiv[`DIV_W-1:1]};   // half bit
            end
         end else if (cnt_q != {`DIV_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
         end else begin
            cnt_q    <= bitDiv - 1'b1;
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == 4'h0) begin
               if (rxd)
                  active_q <= 1'b0;           // glitch, not a start bit
            end else if (bitIdx_q == `FRAME_BITS) begin
               active_q <= 1'b0;
               valid    <= rxd;
               frameErr <= !rxd;
            end else begin
               data <= {rxd, data[7:1]};
            end
         end
      end
   end

endmodule
`default_nettype wire

// ---- rtl/uart_tx_engine.v ----
/*
 Transmit engine: one 8N1 character per start pulse, lsb first.
 Assumes a stable divider while busy.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.vh"

module uart_tx_engine (
   input  wire              sys_clk,
   input  wire              rst,
   input  wire [`DIV_W-1:0] bitDiv,
   input  wire              start,
   input  wire [7:0]        data,
   output reg               txd,
   output reg               busy
);

   reg [`DIV_W-1:0] cnt_q;
   reg [8:0]        shift_q;
   reg [3:0]        bitIdx_q;

   // ----------------------------------------------------------------
   // shift out start, data, stop
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         txd      <= 1'b1;
         busy     <= 1'b0;
         cnt_q    <= {`DIV_W{1'b0}};
         shift_q  <= 9'h1ff;
         bitIdx_q <= 4'h0;
      end else if (!busy) begin
         if (start) begin
            txd      <= 1'b0;                 // start bit
            shift_q  <= {1'b1, data};         // stop bit behind data
            busy     <= 1'b1;
            cnt_q    <= bitDiv - 1'b1;
            bitIdx_q <= 4'h0;
         end
      end else if (cnt_q != {`DIV_W{1'b0}}) begin
         cnt_q <= cnt_q - 1'b1;
      end else if (bitIdx_q == `FRAME_BITS) begin
         busy <= 1'b0;                        // one stop bit done
      end else begin
         txd      <= shift_q[0];
         shift_q  <= {1'b1, shift_q[8:1]};
         bitIdx_q <= bitIdx_q + 4'h1;
         cnt_q    <= bitDiv - 1'b1;
      end
   end

endmodule
`default_nettype wire

// ---- tb/pc_terminal.sv ----
/*
 Far-side terminal model, 8N1, lsb first.
 Assumes bitCyc is the bit time in sys_clk cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module pc_terminal (
   input  wire logic        sys_clk,
   input  wire logic        txd,
   input  wire logic [15:0] bitCyc,
   output logic             rxd,
   output logic             gotStb,
   output logic             gotStop,
   output logic [7:0]       gotByte
);
   logic [7:0] shift;
   int         j;

   // idle line is mark
   initial begin
      rxd = 1'b1;
      gotStb = 1'b0;
      gotStop = 1'b0;
      gotByte = 8'h00;
   end

   // host sender, 8N1 lsb first
   task send(input logic [7:0] b);
      int i;
      @(posedge sys_clk);
      rxd <= 1'b0;
      repeat (bitCyc) @(posedge sys_clk);
      for (i = 0; i < 8; i++) begin
         rxd <= b[i];
         repeat (bitCyc) @(posedge sys_clk);
      end
      rxd <= 1'b1;
      repeat (bitCyc) @(posedge sys_clk);
   endtask

   // host receiver, mid-bit sampling
   always begin
      @(posedge sys_clk);
      if (txd === 1'b0) begin
         repeat (bitCyc / 2) @(posedge sys_clk);
         for (j = 0; j < 8; j++) begin
            repeat (bitCyc) @(posedge sys_clk);
            shift[j] = txd;
         end
         repeat (bitCyc) @(posedge sys_clk);
         gotStop <= txd;
         gotByte <= shift;
         gotStb <= 1'b1;
         @(posedge sys_clk);
         gotStb <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/service_serial_port_alarm_out_test.sv ----
/*
 Bench of the serial port: bus, serial, alarm, breath.
 Assumes design, checker and terminal model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.vh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module service_serial_port_alarm_out_test;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   localparam logic [17:0] PULSE = 18'h00014;
   logic        sys_clk = 1'b0;
   logic        rst, regWr, regRd, rxd, txd, dtrOut, alarmPinOut, alarmPinOe, irq, rdPend;
   logic        mainsPower, alarmSounding, expAlarmSounding, alarmSilenced, breathDetect;
   logic        nvStore, nvBreathOut, gotStb, gotStop;
   logic [4:0]  regAddr;
   logic [31:0] regWrData, regRdData;
   logic [10:0] nvBaudOut;
   logic [7:0]  gotByte;
   logic [15:0] bitCyc, rnd;
   logic [63:0] rdNote;
   logic [8:0]  serNote;
   logic [63:0] rdExp[$];
   logic [8:0]  serExp[$];
   int          n_mismatch, total_checks, cycles, nvCnt, hi, n0, h0;

   service_serial_port_alarm_out #(.PULSE_CYC(PULSE)) service_serial_port_alarm_out_i (
      .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxd(rxd), .txd(txd),
      .dtrOut(dtrOut), .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe),
      .mainsPower(mainsPower), .alarmSounding(alarmSounding),
      .expAlarmSounding(expAlarmSounding), .alarmSilenced(alarmSilenced),
      .alarmFnStrap(1'b1), .breathDetect(breathDetect), .nvBreathIn(1'b0),
      .nvBaudIn(11'h000), .nvStore(nvStore), .nvBreathOut(nvBreathOut),
      .nvBaudOut(nvBaudOut), .irq(irq));
   pc_terminal pc_terminal_i (.sys_clk(sys_clk), .txd(txd), .bitCyc(bitCyc), .rxd(rxd),
      .gotStb(gotStb), .gotStop(gotStop), .gotByte(gotByte));

   // clock, 40 ns period
   always #20 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      rdExp.push_back({m, e & m});
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
   endtask
   task expSer(input logic [7:0] b);
      serExp.push_back({1'b1, b});
   endtask
   task waitSer;
      int k;
      for (k = 0; k < 40000 && serExp.size() > 0; k++) @(posedge sys_clk);
      `CHK("serial drained", 0, serExp.size())
   endtask
   task alm(input logic s, e, q, m, d, o);
      @(posedge sys_clk);
      alarmSounding <= s;
      expAlarmSounding <= e;
      alarmSilenced <= q;
      mainsPower <= m;
      repeat (6) @(negedge sys_clk);
      `CHK("dtrOut", d, dtrOut)
      `CHK("alarmPinOe", o, alarmPinOe)
   endtask
   task breath(input logic en, input int len);
      n0 = nvCnt;
      wr(`REG_CTRL, {31'h0, en});
      @(negedge sys_clk);
      `CHK("nvBreathOut", en, nvBreathOut)
      h0 = hi;
      @(posedge sys_clk);
      breathDetect <= 1'b1;
      repeat (3) @(posedge sys_clk);
      breathDetect <= 1'b0;
      repeat (40) @(posedge sys_clk);
      `CHK("pulse length", len, hi - h0)
      `CHK("nvStore count", 1, nvCnt - n0)
   endtask
   task irqChk(input logic e);
      repeat (2) @(negedge sys_clk);
      `CHK("irq", e, irq)
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // result watcher, counters, hang limit
   always @(posedge sys_clk) begin
      cycles++;
      nvCnt += (nvStore === 1'b1);
      hi += (dtrOut === 1'b1);
      if (rdPend === 1'b1) begin
         rdNote = rdExp.pop_front();
         `CHK("regRdData", rdNote[31:0], regRdData & rdNote[63:32])
      end
      rdPend <= regRd;
      if (gotStb === 1'b1 && serExp.size() > 0) begin
         serNote = serExp.pop_front();
         `CHK("serial byte", serNote, {gotStop, gotByte})
      end
      if (cycles == 60000) begin
         n_mismatch++;
         $display("timeout");
         final_report;
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {regWr, regRd, rdPend, alarmSounding, expAlarmSounding, alarmSilenced} = 6'h00;
      breathDetect = 1'b0;
      mainsPower = 1'b1;
      regAddr = 5'h00;
      regWrData = 32'h0;
      bitCyc = 16'h0516;
      rnd = 16'h0063;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(`REG_BAUD, 32'h7ff, 32'h0c0);
      rd(5'h1c, 32'hffffffff, 32'h0);
      rnd = lfsr(rnd);
      expSer(rnd[7:0]);
      wr(`REG_TXDATA, {24'h0, rnd[7:0]});
      waitSer;
      $display("test default rate done");
      wr(`REG_BAUD, 32'h7ff);
      wr(`REG_BAUD, 32'h0);
      rd(`REG_BAUD, 32'h7ff, 32'h7ff);
      bitCyc <= 16'(32'h0003d090 / 32'h000007ff);
      rnd = lfsr(rnd);
      pc_terminal_i.send(rnd[7:0]);
      repeat (4) @(posedge sys_clk);
      rd(`REG_RXDATA, 32'hff, {24'h0, rnd[7:0]});
      rd(`REG_IRQ_STAT, 32'h1, 32'h1);
      $display("test receive done");
      wr(`REG_CTRL, {29'h0, `MODE_LOOPBACK, 1'b0});
      for (n0 = 0; n0 < 2; n0++) begin
         rnd = lfsr(rnd);
         expSer(rnd[7:0]);
         pc_terminal_i.send(rnd[7:0]);
      end
      waitSer;
      $display("test loopback done");
      wr(`REG_CTRL, {29'h0, `MODE_TXTEST, 1'b0});
      for (n0 = 0; n0 < 4; n0++) expSer(n0[7:0]);
      waitSer;
      mainsPower <= 1'b0;
      rd(`REG_CTRL, 32'h6, 32'h0);
      wr(`REG_CTRL, {29'h0, `MODE_LOOPBACK, 1'b0});
      rd(`REG_CTRL, 32'h6, 32'h0);
      $display("test pattern done");
      alm(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      alm(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      alm(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      alm(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      $display("test alarm done");
      wr(`REG_IRQ_STAT, 32'h1f);
      wr(`REG_IRQ_MASK, 32'h1 << `IRQ_BREATH);
      breath(1'b1, int'(PULSE));
      irqChk(1'b1);
      wr(`REG_IRQ_MASK, 32'h0);
      irqChk(1'b0);
      wr(`REG_IRQ_MASK, 32'h1 << `IRQ_BREATH);
      irqChk(1'b1);
      wr(`REG_IRQ_STAT, 32'h1 << `IRQ_BREATH);
      irqChk(1'b0);
      breath(1'b0, 0);
      $display("test breath done");
      repeat (4) @(posedge sys_clk);
      final_report;
   end
endmodule

bind service_serial_port_alarm_out ssp_checker #(.PULSE_CYC(PULSE_CYC)) ssp_checker_i (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dtrOut(dtrOut),
   .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe), .alarmSounding(alarmSounding),
   .expAlarmSounding(expAlarmSounding), .alarmSilenced(alarmSilenced),
   .alarmFnStrap(alarmFnStrap), .breathDetect(breathDetect), .nvStore(nvStore),
   .nvBaudOut(nvBaudOut));
`default_nettype wire

// ---- tb/ssp_checker_asserts.sv ----
/*
 Port-level assertions of the serial port.
 Assumes a bind onto the top with PULSE_CYC handed on.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.vh"

module ssp_checker #(
   parameter logic [17:0] PULSE_CYC = 18'h00014
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [4:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   input wire logic        dtrOut,
   input wire logic        alarmPinOut,
   input wire logic        alarmPinOe,
   input wire logic        alarmSounding,
   input wire logic        expAlarmSounding,
   input wire logic        alarmSilenced,
   input wire logic        alarmFnStrap,
   input wire logic        breathDetect,
   input wire logic        nvStore,
   input wire logic [10:0] nvBaudOut
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic        act;
   logic        fnEn_q;
   logic        breathPrev_q;
   logic [2:0]  sinceRst_q;
   logic [17:0] sinceBreath_q;

   // any alarm sounding and not silenced
   assign act = (alarmSounding | expAlarmSounding) & ~alarmSilenced;

   // strap, cycles since reset and since last breath
   always_ff @(posedge sys_clk) begin
      breathPrev_q <= breathDetect;
      if (rst) begin
         sinceRst_q <= 3'h0;
         fnEn_q <= 1'b0;
         sinceBreath_q <= 18'h3ffff;
      end else begin
         if (sinceRst_q == 3'h0) fnEn_q <= alarmFnStrap;
         if (sinceRst_q != 3'h7) sinceRst_q <= sinceRst_q + 3'h1;
         if (breathDetect & ~breathPrev_q) sinceBreath_q <= 18'h0;
         else if (sinceBreath_q != 18'h3ffff) sinceBreath_q <= sinceBreath_q + 18'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   pin_on_a: assert property (act [*4] ##0 (sinceRst_q == 3'h7) |-> alarmPinOe)
      else $error("pin not pulled");
   pin_off_a: assert property (!act [*4] ##0 (sinceRst_q == 3'h7) |-> !alarmPinOe)
      else $error("pin pulled idle");
   pin_ground_a: assert property (alarmPinOe |-> !alarmPinOut)
      else $error("pin driven high");
   dtr_alarm_a: assert property (act [*4] ##0 (fnEn_q && sinceRst_q == 3'h7) |-> dtrOut)
      else $error("dtr low during alarm");
   dtr_breath_a: assert property (!act [*4] ##0 dtrOut |-> sinceBreath_q <= PULSE_CYC + 18'h4)
      else $error("stray dtr");
   silence_low_a: assert property (alarmSilenced [*4] ##0 (sinceBreath_q > PULSE_CYC + 18'h4) |-> !dtrOut && !alarmPinOe)
      else $error("held after silence");
   baud_store_a: assert property (regWr && regAddr == `REG_BAUD && regWrData[10:0] != 11'h0 |=> nvStore && nvBaudOut == $past(regWrData[10:0]))
      else $error("rate not stored");
   store_quiet_a: assert property (!regWr |=> !nvStore)
      else $error("stray store");
   rd_idle_a: assert property (!regRd |=> regRdData == 32'h0)
      else $error("stray read data");
   rd_unmapped_a: assert property (regRd && regAddr > 5'h18 |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire
